// file: hw/dtsc_ctrl.sv
// dtsc_ctrl: serial terminal controller at device address 7.
// assumes processor commands arrive on a plain strobe port in core_clk.
`timescale 1ns/1ns
`include "dtsc_params.svh"

module dtsc_ctrl #(
    parameter int unsigned MOTOR_CYC = `DTSC_MOTOR_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // processor command port
    input wire logic [6:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [15:0] io_rdata,
    output logic io_retry,
    // interrupts and count-exhausted acknowledges
    input wire logic eob_ack_out,
    input wire logic eob_ack_in,
    input wire logic irq_ack,
    output logic irq_req,
    output logic [1:0] irq_code,
    // terminal line and controls
    input wire logic rx_in,
    output logic tx_out,
    input wire logic cts_in,
    output logic rts_out,
    output logic motor_on,
    output logic reader_run,
    output logic reader_step,
    input wire logic reader_start_sw,
    input wire logic tape_out,
    // straps
    input wire logic parity_strap,
    input wire logic rs232_strap
);

    dtsc_pkg::dtsc_state_t s_ff;
    dtsc_pkg::dtsc_state_t nxt_s;
    logic [3:0] op;
    logic [2:0] fn;
    logic rx_line;
    logic busy;
    logic quiet;

    assign op = io_addr[6:3];
    assign fn = io_addr[2:0];
    assign rx_line = s_ff.diag ? s_ff.tx_line : rx_in;
    assign busy = s_ff.out_full || s_ff.tx_st != dtsc_pkg::LN_IDLE
        || s_ff.rx_st != dtsc_pkg::LN_IDLE;
    assign quiet = s_ff.hold == 32'h0000_0000;

    function automatic logic tick(input logic [15:0] cnt);
        tick = cnt == 16'(`DTSC_BIT_CYC - 1);
    endfunction

    // low byte from the buffer; high byte either cleared or kept
    function automatic logic [15:0] to_reg(input logic [7:0] b,
        input logic [15:0] r, input logic keep_hi);
        to_reg = {keep_hi ? r[15:8] : 8'h00, b};
    endfunction

    always_comb begin
        logic empty_ev;
        logic full_ev;
        logic is_init;
        empty_ev = 1'b0;
        full_ev = 1'b0;
        is_init = 1'b0;
        nxt_s = s_ff;
        nxt_s.reader_step = 1'b0;
        nxt_s.retry = 1'b0;
        nxt_s.rdata = 16'h0000;
        if (!quiet) begin
            nxt_s.hold = s_ff.hold - 32'h0000_0001;
        end

        // transmitter: start, eight data bits, stop
        case (s_ff.tx_st)
            dtsc_pkg::LN_IDLE: begin
                if (s_ff.out_full) begin
                    nxt_s.tx_sh = {1'b1, s_ff.out_buf, 1'b0};
                    nxt_s.out_full = 1'b0;
                    empty_ev = 1'b1;
                    nxt_s.tx_cnt = 16'h0000;
                    nxt_s.tx_bit = 4'h0;
                    nxt_s.tx_st = dtsc_pkg::LN_DATA;
                end
            end
            dtsc_pkg::LN_DATA: begin
                nxt_s.tx_cnt = s_ff.tx_cnt + 16'h0001;
                if (tick(s_ff.tx_cnt)) begin
                    nxt_s.tx_cnt = 16'h0000;
                    nxt_s.tx_sh = {1'b1, s_ff.tx_sh[9:1]};
                    nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
                    if (s_ff.tx_bit == 4'h9) begin
                        nxt_s.tx_st = dtsc_pkg::LN_IDLE;
                    end
                end
            end
            default: nxt_s.tx_st = dtsc_pkg::LN_IDLE;
        endcase

        // receiver: mid-bit sampling from the start edge
        case (s_ff.rx_st)
            dtsc_pkg::LN_IDLE: begin
                nxt_s.rx_cnt = 16'h0000;
                if (!rx_line) begin
                    nxt_s.rx_st = dtsc_pkg::LN_START;
                end
            end
            dtsc_pkg::LN_START: begin
                nxt_s.rx_cnt = s_ff.rx_cnt + 16'h0001;
                if (s_ff.rx_cnt == 16'(`DTSC_HALF_CYC - 1)) begin
                    nxt_s.rx_cnt = 16'h0000;
                    nxt_s.rx_bit = 4'h0;
                    // a glitch shorter than half a bit is no start
                    nxt_s.rx_st = rx_line ? dtsc_pkg::LN_IDLE : dtsc_pkg::LN_DATA;
                end
            end
            dtsc_pkg::LN_DATA: begin
                nxt_s.rx_cnt = s_ff.rx_cnt + 16'h0001;
                if (tick(s_ff.rx_cnt)) begin
                    nxt_s.rx_cnt = 16'h0000;
                    nxt_s.rx_sh = {rx_line, s_ff.rx_sh[7:1]};
                    nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
                    if (s_ff.rx_bit == 4'h7) begin
                        nxt_s.rx_st = dtsc_pkg::LN_STOP;
                    end
                end
            end
            dtsc_pkg::LN_STOP: begin
                nxt_s.rx_cnt = s_ff.rx_cnt + 16'h0001;
                if (tick(s_ff.rx_cnt)) begin
                    nxt_s.rx_st = dtsc_pkg::LN_IDLE;
                    nxt_s.in_buf = s_ff.rx_sh;
                    nxt_s.in_full = 1'b1;
                    full_ev = 1'b1;
                    // even parity carried in bit 7 when strapped
                    nxt_s.par_err = parity_strap && ^s_ff.rx_sh;
                    if (s_ff.echo_en && !nxt_s.out_full) begin
                        nxt_s.out_buf = s_ff.rx_sh;
                        nxt_s.out_full = 1'b1;
                    end
                end
            end
            default: nxt_s.rx_st = dtsc_pkg::LN_IDLE;
        endcase

        if (tape_out) begin
            nxt_s.reader_run = 1'b0;
        end

        if (io_wr) begin
            case (op)
                `DTSC_OP_SELECT: begin
                    case (fn)
                        `DTSC_FN_ECHO: nxt_s.echo_en = 1'b1;
                        `DTSC_FN_KEYBOARD: nxt_s.reader_run = 1'b0;
                        `DTSC_FN_STEP: nxt_s.reader_step = reader_start_sw;
                        `DTSC_FN_CONT: begin
                            nxt_s.reader_run = reader_start_sw;
                        end
                        `DTSC_FN_INIT: begin
                            is_init = 1'b1;
                            nxt_s.full_duplex = 1'b0;
                            nxt_s.diag = 1'b0;
                        end
                        `DTSC_FN_WORD_MASK: nxt_s.m_ow = 1'b1;
                        `DTSC_FN_EOB_MASK: nxt_s.m_oe = 1'b1;
                        `DTSC_FN_DISABLE: begin
                            nxt_s.m_ow = 1'b0;
                            nxt_s.m_oe = 1'b0;
                            nxt_s.p_ow = 1'b0;
                            nxt_s.p_oe = 1'b0;
                        end
                        default: ;
                    endcase
                end
                `DTSC_OP_SELECT_REG: begin
                    if (fn == `DTSC_FN_INIT && (io_wdata == `DTSC_OPERAND_ONE
                        || io_wdata == `DTSC_OPERAND_DIAG)) begin
                        is_init = 1'b1;
                        nxt_s.full_duplex = 1'b1;
                        nxt_s.diag = io_wdata == `DTSC_OPERAND_DIAG;
                    end
                    if (io_wdata == `DTSC_OPERAND_ONE) begin
                        case (fn)
                            `DTSC_FN_WORD_MASK: nxt_s.m_iw = 1'b1;
                            `DTSC_FN_EOB_MASK: nxt_s.m_ie = 1'b1;
                            `DTSC_FN_DISABLE: begin
                                nxt_s.m_iw = 1'b0;
                                nxt_s.m_ie = 1'b0;
                                nxt_s.p_iw = 1'b0;
                                nxt_s.p_ie = 1'b0;
                            end
                            default: ;
                        endcase
                    end
                end
                `DTSC_OP_ZERO_OUT: begin
                    // the same codes serve a modem line or a motor line
                    if (fn == `DTSC_FN_EOB_MASK) begin
                        if (rs232_strap) begin
                            nxt_s.rts = 1'b0;
                        end else begin
                            nxt_s.motor = 1'b1;
                            nxt_s.hold = MOTOR_CYC;
                        end
                    end else if (fn == `DTSC_FN_DISABLE) begin
                        if (rs232_strap) begin
                            nxt_s.rts = 1'b1;
                        end else begin
                            nxt_s.motor = 1'b0;
                        end
                    end
                end
                `DTSC_OP_OUT_UNCOND: begin
                    nxt_s.out_buf = io_wdata[7:0];
                    nxt_s.out_full = 1'b1;
                end
                `DTSC_OP_WRITE_EMPTY, `DTSC_OP_BLOCK_OUT: begin
                    if (s_ff.out_full) begin
                        nxt_s.retry = 1'b1;
                    end else begin
                        nxt_s.out_buf = io_wdata[7:0];
                        nxt_s.out_full = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (is_init) begin
            // echo, reader, mask, pending and buffer flags clear; motor and rts keep their state; the line returns to marking
            nxt_s.echo_en = 1'b0;
            nxt_s.reader_run = 1'b0;
            {nxt_s.m_ow, nxt_s.m_oe, nxt_s.m_iw, nxt_s.m_ie} = 4'h0;
            {nxt_s.p_ow, nxt_s.p_oe, nxt_s.p_iw, nxt_s.p_ie} = 4'h0;
            nxt_s.out_full = 1'b0;
            nxt_s.in_full = 1'b0;
            nxt_s.par_err = 1'b0;
            nxt_s.tx_st = dtsc_pkg::LN_IDLE;
            nxt_s.tx_sh = 10'h3FF;
            nxt_s.rx_st = dtsc_pkg::LN_IDLE;
            empty_ev = 1'b0;
            full_ev = 1'b0;
        end

        if (io_rd) begin
            case (op)
                `DTSC_OP_SENSE: begin
                    case (fn)
                        3'h0: nxt_s.rdata[0] = s_ff.in_full;
                        3'h1: nxt_s.rdata[0] = !s_ff.out_full;
                        3'h2: nxt_s.rdata[0] = s_ff.m_ow;
                        3'h3: nxt_s.rdata[0] = !busy;
                        3'h4: nxt_s.rdata[0] = rs232_strap && cts_in;
                        3'h5: nxt_s.rdata[0] = s_ff.motor;
                        3'h6: nxt_s.rdata[0] = s_ff.par_err;
                        3'h7: nxt_s.rdata[0] = s_ff.full_duplex;
                        default: ;
                    endcase
                    // motor run-up mutes every sense answer
                    if (!quiet) begin
                        nxt_s.rdata[0] = 1'b0;
                    end
                end
                `DTSC_OP_IN_WORD, `DTSC_OP_IN_BYTE: begin
                    nxt_s.rdata = to_reg(s_ff.in_buf, io_wdata,
                        op == `DTSC_OP_IN_BYTE);
                    nxt_s.in_full = full_ev;
                end
                `DTSC_OP_READ_WORD, `DTSC_OP_READ_BYTE, `DTSC_OP_BLOCK_IN: begin
                    if (!s_ff.in_full) begin
                        nxt_s.retry = 1'b1;
                    end else begin
                        nxt_s.rdata = to_reg(s_ff.in_buf, io_wdata,
                            op == `DTSC_OP_READ_BYTE);
                        nxt_s.in_full = full_ev;
                    end
                end
                default: ;
            endcase
        end

        // acknowledge clears the served request; new events set after
        if (irq_ack && irq_req) begin
            case (irq_code)
                `DTSC_IRQ_IN_EOB: nxt_s.p_ie = 1'b0;
                `DTSC_IRQ_OUT_EOB: nxt_s.p_oe = 1'b0;
                `DTSC_IRQ_IN_WORD: nxt_s.p_iw = 1'b0;
                default: nxt_s.p_ow = 1'b0;
            endcase
        end
        if (empty_ev && nxt_s.m_ow) begin
            nxt_s.p_ow = 1'b1;
        end
        if (full_ev && nxt_s.m_iw) begin
            nxt_s.p_iw = 1'b1;
        end
        if (eob_ack_out && nxt_s.m_oe) begin
            nxt_s.p_oe = 1'b1;
        end
        if (eob_ack_in && nxt_s.m_ie) begin
            nxt_s.p_ie = 1'b1;
        end
        nxt_s.tx_line = nxt_s.tx_sh[0];
        if (nxt_s.tx_st == dtsc_pkg::LN_IDLE) begin
            nxt_s.tx_line = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_ff <= '0;
            s_ff.motor <= 1'b1;
            s_ff.tx_line <= 1'b1;
            s_ff.tx_sh <= 10'h3FF;
        end else begin
            s_ff <= nxt_s;
        end
    end

    always_comb begin
        irq_req = quiet && (s_ff.p_ie || s_ff.p_oe || s_ff.p_iw || s_ff.p_ow);
        if (s_ff.p_ie) begin
            irq_code = `DTSC_IRQ_IN_EOB;
        end else if (s_ff.p_oe) begin
            irq_code = `DTSC_IRQ_OUT_EOB;
        end else if (s_ff.p_iw) begin
            irq_code = `DTSC_IRQ_IN_WORD;
        end else begin
            irq_code = `DTSC_IRQ_OUT_WORD;
        end
    end

    assign io_rdata = s_ff.rdata;
    assign io_retry = s_ff.retry;
    assign tx_out = s_ff.tx_line;
    assign rts_out = s_ff.rts;
    assign motor_on = s_ff.motor;
    assign reader_run = s_ff.reader_run;
    assign reader_step = s_ff.reader_step;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence half_init;
        io_wr && op == `DTSC_OP_SELECT && fn == `DTSC_FN_INIT;
    endsequence
    sequence diag_init;
        io_wr && op == `DTSC_OP_SELECT_REG && fn == `DTSC_FN_INIT
            && io_wdata == `DTSC_OPERAND_DIAG;
    endsequence

    a_init_echo_off: assert property (half_init |=> !s_ff.echo_en)
        else $error("echo still on after init");
    a_kbd_reader_stop: assert property (io_wr && op == `DTSC_OP_SELECT
        && fn == `DTSC_FN_KEYBOARD |=> !reader_run && $stable(s_ff.m_ow))
        else $error("keyboard select misbehaved");
    a_step_pulse: assert property (io_wr && op == `DTSC_OP_SELECT
        && fn == `DTSC_FN_STEP && reader_start_sw |=> reader_step
        ##1 (!reader_step || $past(io_wr && op == `DTSC_OP_SELECT && fn == `DTSC_FN_STEP)))
        else $error("step pulse wrong");
    a_half_marking: assert property (half_init |=> !s_ff.full_duplex && tx_out)
        else $error("half duplex init not marking");
    a_diag_loop: assert property (diag_init |=> s_ff.diag && s_ff.full_duplex)
        else $error("diagnostic init failed");
    a_hold_mute: assert property (!quiet |-> !irq_req)
        else $error("interrupt during motor run-up");
    a_sense_full: assert property (io_rd && op == `DTSC_OP_SENSE
        && fn == 3'h0 && quiet |=> io_rdata[0] == $past(s_ff.in_full))
        else $error("sense input full wrong");
    a_write_retry: assert property (io_wr && op == `DTSC_OP_WRITE_EMPTY
        && s_ff.out_full |=> io_retry)
        else $error("busy write not repeated");
    a_irq_order: assert property (s_ff.p_ie && quiet
        |-> irq_req && irq_code == `DTSC_IRQ_IN_EOB)
        else $error("input end-of-block not first");
    a_word_irq: assert property (s_ff.out_full && s_ff.m_ow
        && s_ff.tx_st == dtsc_pkg::LN_IDLE && !io_wr |=> s_ff.p_ow)
        else $error("output word interrupt missing");

endmodule // dtsc_ctrl

// file: hw/dtsc_params.svh
// dtsc_params.svh: constants of the duplex terminal serial controller.
// assumes inclusion by bare name from every file that needs the command map.
`ifndef DTSC_PARAMS_SVH
`define DTSC_PARAMS_SVH

`define DTSC_CLK_HZ 100000000
`define DTSC_MOTOR_MS 600
`define DTSC_MOTOR_CYC ((`DTSC_MOTOR_MS) * (`DTSC_CLK_HZ / 1000))
`define DTSC_BIT_CYC 16
`define DTSC_HALF_CYC 8

// command index: io_addr[6:3]
`define DTSC_OP_SELECT 4'h0
`define DTSC_OP_SELECT_REG 4'h1
`define DTSC_OP_SENSE 4'h2
`define DTSC_OP_ZERO_OUT 4'h3
`define DTSC_OP_OUT_UNCOND 4'h4
`define DTSC_OP_WRITE_EMPTY 4'h5
`define DTSC_OP_IN_WORD 4'h6
`define DTSC_OP_IN_BYTE 4'h7
`define DTSC_OP_READ_WORD 4'h8
`define DTSC_OP_READ_BYTE 4'h9
`define DTSC_OP_BLOCK_OUT 4'hA
`define DTSC_OP_BLOCK_IN 4'hB

// function field: io_addr[2:0]
`define DTSC_FN_ECHO 3'h0
`define DTSC_FN_KEYBOARD 3'h1
`define DTSC_FN_STEP 3'h2
`define DTSC_FN_CONT 3'h3
`define DTSC_FN_INIT 3'h4
`define DTSC_FN_WORD_MASK 3'h5
`define DTSC_FN_EOB_MASK 3'h6
`define DTSC_FN_DISABLE 3'h7

`define DTSC_OPERAND_ONE 16'h0001
`define DTSC_OPERAND_DIAG 16'h0003

// irq_code values in priority order
`define DTSC_IRQ_IN_EOB 2'h0
`define DTSC_IRQ_OUT_EOB 2'h1
`define DTSC_IRQ_IN_WORD 2'h2
`define DTSC_IRQ_OUT_WORD 2'h3

`endif

// file: hw/dtsc_pkg.sv
// dtsc_pkg: types of the duplex terminal serial controller.
// assumes the controller keeps all its state in one packed struct.
package dtsc_pkg;

    typedef enum logic [1:0] {LN_IDLE, LN_START, LN_DATA, LN_STOP} dtsc_line_st_t;

    typedef struct packed {
        logic full_duplex;
        logic diag;
        logic echo_en;
        logic reader_run;
        logic reader_step;
        logic motor;
        logic rts;
        logic m_ow;
        logic m_oe;
        logic m_iw;
        logic m_ie;
        logic p_ow;
        logic p_oe;
        logic p_iw;
        logic p_ie;
        logic out_full;
        logic in_full;
        logic par_err;
        logic [7:0] out_buf;
        logic [7:0] in_buf;
        dtsc_line_st_t tx_st;
        dtsc_line_st_t rx_st;
        logic [9:0] tx_sh;
        logic [7:0] rx_sh;
        logic [3:0] tx_bit;
        logic [3:0] rx_bit;
        logic [15:0] tx_cnt;
        logic [15:0] rx_cnt;
        logic [31:0] hold;
        logic [15:0] rdata;
        logic retry;
        logic tx_line;
    } dtsc_state_t;

endpackage

// file: sim/dtsc_term_model.sv
// dtsc_term_model: terminal at the far end of the serial line.
// assumes 8 data bits LSB first, one stop bit, BIT_CYC core_clk cycles a bit.
`timescale 1ns/1ns
module dtsc_term_model #(
    parameter int BIT_CYC = 16
) (
    // clock
    input wire logic core_clk,
    // line
    input wire logic tx_out,
    output logic rx_in,
    // capture
    output logic [7:0] got,
    output logic [7:0] got_n
);
    initial begin
        rx_in = 1'b1;
        got = 8'h00;
        got_n = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_in <= f[i];
            repeat (BIT_CYC) @(posedge core_clk);
        end
    endtask
    // mid-bit sampling tolerates a cycle of skew on the start edge
    always begin
        @(negedge tx_out);
        repeat (BIT_CYC / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge core_clk);
            got[i] = tx_out;
        end
        got_n = got_n + 8'h01;
        repeat (BIT_CYC) @(posedge core_clk);
    end
endmodule // dtsc_term_model

// file: sim/dtsc_ctrl_tb.sv
// dtsc_ctrl_tb: self-checking bench of the terminal serial controller.
// assumes dtsc_params.svh on the include path; motor hold cut to 50 cycles.
`timescale 1ns/1ns
`include "dtsc_params.svh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, e, a); end end
module dtsc_ctrl_tb;
    localparam int HOLD = 50;
    typedef struct packed {logic rd; logic [3:0] op; logic [2:0] fn; logic [15:0] d;
        logic [15:0] q; logic rt;} dtsc_row_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [6:0] io_addr = 7'h00;
    logic [15:0] io_wdata = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic eob_ack_out = 1'b0;
    logic eob_ack_in = 1'b0;
    logic irq_ack = 1'b0;
    logic cts_in = 1'b0;
    logic rs232_strap = 1'b0;
    logic reader_start_sw = 1'b1, tape_out = 1'b0, parity_strap = 1'b1;
    logic [15:0] io_rdata, q;
    logic io_retry, irq_req, rx_in, tx_out, rts_out, motor_on, reader_run, reader_step, rt;
    logic [1:0] irq_code;
    logic [7:0] got, got_n;
    int err_total = 0;
    int checks_done = 0;
    dtsc_row_t rows [12] = '{
        '{1'b1, 4'h2, 3'h0, 16'h0000, 16'h0000, 1'b0},
        '{1'b1, 4'h2, 3'h1, 16'h0000, 16'h0001, 1'b0},
        '{1'b1, 4'h2, 3'h3, 16'h0000, 16'h0001, 1'b0},
        '{1'b1, 4'h2, 3'h5, 16'h0000, 16'h0001, 1'b0},
        '{1'b0, 4'h0, 3'h5, 16'h0000, 16'h0000, 1'b0},
        '{1'b1, 4'h2, 3'h2, 16'h0000, 16'h0001, 1'b0},
        '{1'b1, 4'h2, 3'h7, 16'h0000, 16'h0000, 1'b0},
        '{1'b0, 4'h1, 3'h4, 16'h0001, 16'h0000, 1'b0},
        '{1'b1, 4'h2, 3'h7, 16'h0000, 16'h0001, 1'b0},
        '{1'b1, 4'h2, 3'h2, 16'h0000, 16'h0000, 1'b0},
        '{1'b1, 4'h9, 3'h0, 16'hFFFF, 16'h0000, 1'b1},
        '{1'b1, 4'hB, 3'h0, 16'hFFFF, 16'h0000, 1'b1}
    };

    dtsc_ctrl #(.MOTOR_CYC(HOLD)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata), .io_retry(io_retry), .eob_ack_out(eob_ack_out),
        .eob_ack_in(eob_ack_in), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_code(irq_code), .rx_in(rx_in), .tx_out(tx_out), .cts_in(cts_in),
        .rts_out(rts_out), .motor_on(motor_on), .reader_run(reader_run),
        .reader_step(reader_step), .reader_start_sw(reader_start_sw), .tape_out(tape_out),
        .parity_strap(parity_strap), .rs232_strap(rs232_strap));
    dtsc_term_model u_term (.core_clk(core_clk), .tx_out(tx_out), .rx_in(rx_in),
        .got(got), .got_n(got_n));

    always #5 core_clk = ~core_clk;

    task automatic cmd(input logic rd, input logic [3:0] op, input logic [2:0] fn,
        input logic [15:0] d);
        @(posedge core_clk);
        io_addr <= {op, fn};
        io_wdata <= d;
        io_wr <= ~rd;
        io_rd <= rd;
        @(posedge core_clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        @(negedge core_clk);
        q = io_rdata;
        rt = io_retry;
    endtask
    // k = {eob_ack_out, eob_ack_in, irq_ack}
    task automatic pulse(input logic [2:0] k);
        @(posedge core_clk);
        {eob_ack_out, eob_ack_in, irq_ack} <= k;
        @(posedge core_clk);
        {eob_ack_out, eob_ack_in, irq_ack} <= 3'b000;
        @(negedge core_clk);
    endtask
    task automatic wait_n(input logic [7:0] n);
        for (int i = 0; i < 400 && got_n !== n; i++) @(posedge core_clk);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #300000;
        err_total++;
        results();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            cmd(rows[i].rd, rows[i].op, rows[i].fn, rows[i].d);
            `CHK("row data", rows[i].q, q)
            `CHK("row retry", rows[i].rt, rt)
        end
        // third write meets a busy shifter and a loaded buffer
        cmd(1'b0, 4'h0, 3'h5, 16'h0000);
        cmd(1'b0, 4'h5, 3'h1, 16'hFF5A);
        cmd(1'b0, 4'hA, 3'h1, 16'hAB33);
        cmd(1'b0, 4'h5, 3'h1, 16'h0044);
        `CHK("write retry", 1'b1, rt)
        `CHK("out word irq", {1'b1, `DTSC_IRQ_OUT_WORD}, {irq_req, irq_code})
        wait_n(8'h01);
        `CHK("line char 1", 8'h5A, got)
        wait_n(8'h02);
        `CHK("line char 2", 8'h33, got)
        cmd(1'b0, 4'h1, 3'h5, 16'h0001);
        u_term.send(8'hC3);
        for (int i = 0; i < 40 && irq_req !== 1'b1; i++) @(posedge core_clk);
        `CHK("in word irq", `DTSC_IRQ_IN_WORD, irq_code)
        cmd(1'b1, 4'h2, 3'h6, 16'h0000);
        `CHK("parity ok", 16'h0000, q)
        cmd(1'b1, 4'h8, 3'h0, 16'hFFFF);
        `CHK("read word", 16'h00C3, q)
        cmd(1'b0, 4'h0, 3'h0, 16'h0000);
        u_term.send(8'h07);
        wait_n(8'h03);
        `CHK("echo char", 8'h07, got)
        cmd(1'b1, 4'h2, 3'h6, 16'h0000);
        `CHK("parity bad", 16'h0001, q)
        cmd(1'b0, 4'h0, 3'h6, 16'h0000);
        cmd(1'b0, 4'h1, 3'h6, 16'h0001);
        pulse(3'b110);
        `CHK("irq top", `DTSC_IRQ_IN_EOB, irq_code)
        pulse(3'b001);
        `CHK("irq second", `DTSC_IRQ_OUT_EOB, irq_code)
        pulse(3'b001);
        `CHK("irq third", `DTSC_IRQ_IN_WORD, irq_code)
        cmd(1'b0, 4'h0, 3'h7, 16'h0000);
        cmd(1'b0, 4'h1, 3'h7, 16'h0001);
        pulse(3'b110);
        `CHK("irq off", 1'b0, irq_req)
        cmd(1'b0, 4'h1, 3'h4, 16'h0003);
        parity_strap <= 1'b0;
        cmd(1'b0, 4'h4, 3'h0, 16'h12A4);
        q = 16'h0000;
        for (int i = 0; i < 100 && q !== 16'h0001; i++) cmd(1'b1, 4'h2, 3'h0, 16'h0000);
        cmd(1'b1, 4'h7, 3'h0, 16'h3C00);
        `CHK("loop byte", 16'h3CA4, q)
        cmd(1'b1, 4'h6, 3'h0, 16'hFFFF);
        `CHK("in word", 16'h00A4, q)
        cmd(1'b1, 4'h2, 3'h6, 16'h0000);
        `CHK("parity strap off", 16'h0000, q)
        cmd(1'b0, 4'h3, 3'h6, 16'h0000);
        cmd(1'b1, 4'h2, 3'h5, 16'h0000);
        `CHK("motor hold", 16'h0000, q)
        repeat (HOLD) @(posedge core_clk);
        cmd(1'b1, 4'h2, 3'h5, 16'h0000);
        `CHK("motor sense", 16'h0001, q)
        cmd(1'b0, 4'h3, 3'h7, 16'h0000);
        `CHK("motor off", 1'b0, motor_on)
        @(posedge core_clk);
        rs232_strap <= 1'b1;
        cts_in <= 1'b1;
        cmd(1'b0, 4'h3, 3'h7, 16'h0000);
        `CHK("rts on", 1'b1, rts_out)
        cmd(1'b1, 4'h2, 3'h4, 16'h0000);
        `CHK("cts", 16'h0001, q)
        cmd(1'b0, 4'h3, 3'h6, 16'h0000);
        `CHK("rts off", 1'b0, rts_out)
        cmd(1'b0, 4'h0, 3'h3, 16'h0000);
        `CHK("reader run", 1'b1, reader_run)
        cmd(1'b0, 4'h0, 3'h1, 16'h0000);
        `CHK("reader stop", 1'b0, reader_run)
        cmd(1'b0, 4'h0, 3'h3, 16'h0000);
        @(posedge core_clk);
        tape_out <= 1'b1;
        @(posedge core_clk);
        tape_out <= 1'b0;
        @(negedge core_clk);
        `CHK("tape out", 1'b0, reader_run)
        reader_start_sw <= 1'b0;
        cmd(1'b0, 4'h0, 3'h3, 16'h0000);
        `CHK("switch off run", 1'b0, reader_run)
        cmd(1'b0, 4'h0, 3'h2, 16'h0000);
        `CHK("switch off step", 1'b0, reader_step)
        reader_start_sw <= 1'b1;
        cmd(1'b0, 4'h0, 3'h2, 16'h0000);
        `CHK("reader step", 1'b1, reader_step)
        cmd(1'b0, 4'h0, 3'h4, 16'h0000);
        cmd(1'b1, 4'h2, 3'h7, 16'h0000);
        `CHK("half duplex", 16'h0000, q)
        `CHK("marking", 1'b1, tx_out)
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK("reset motor", 1'b1, motor_on)
        @(posedge core_clk);
        sys_rst <= 1'b0;
        results();
    end
endmodule // dtsc_ctrl_tb
